// File: hw/timer_core_pkg.sv
package timer_core_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ctrl_offset = 8'h00;
	localparam logic [7:0] compare_buffer0_offset = 8'h04;
	localparam logic [7:0] compare_buffer1_offset = 8'h08;
	localparam logic [7:0] count_offset = 8'h0c;
	localparam logic [7:0] status_offset = 8'h10;
	localparam logic [7:0] prescale_offset = 8'h14;

	// ==========================================================
	// control field positions
	localparam int ctrl_enable_bit = 0;
	localparam int ctrl_mode_lsb = 1;
	localparam int ctrl_unit0_bit = 4;
	localparam int ctrl_event_src_bit = 5;
	localparam int ctrl_edge_lsb = 6;
	localparam int ctrl_capture_clear_bit = 8;

	// ==========================================================
	// status field positions
	localparam int status_ovf_bit = 0;
	localparam int status_out0_bit = 1;
	localparam int status_out1_bit = 2;

	// ==========================================================
	// values
	localparam logic [15:0] count_all_ones = 16'hffff;
	localparam logic [15:0] count_zero = 16'h0000;
	localparam logic [15:0] ccr_reset = 16'hffff;
	localparam logic [15:0] prescale_reset = 16'h0000;

	typedef enum logic [2:0] {
		mode_interval = 3'b000,
		mode_event_count = 3'b001,
		mode_ext_trigger = 3'b010,
		mode_one_shot = 3'b011,
		mode_pwm = 3'b100,
		mode_free_run = 3'b101,
		mode_pulse_width = 3'b110,
		mode_reserved = 3'b111
	} mode_t;

	typedef enum logic [1:0] {
		edge_rising = 2'b00,
		edge_falling = 2'b01,
		edge_both = 2'b10,
		edge_none = 2'b11
	} edge_sel_t;

endpackage

// File: hw/count_tick_gen.sv
`timescale 1ns/1ps
// count-clock enable: prescaler pulse or synchronised external edge
module count_tick_gen
	import timer_core_pkg::*;
#(
	parameter int prescale_width = 16
) (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic run, // counting enabled
	input wire logic use_event, // 1: external edges, 0: prescaler
	input wire edge_sel_t edge_sel, // valid edge of event input
	input wire logic [prescale_width-1:0] prescale, // divide by prescale+1
	input wire logic event_count_input, // external event pin
	output logic tick // one-cycle count enable
);
	initial begin
		if (prescale_width < 1 || prescale_width > 16) $error("prescale_width out of range");
	end

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
		logic [prescale_width-1:0] div;
	} state_t;

	state_t st, next_st;
	logic rise, fall, edge_hit, div_hit;

	always_comb begin
		next_st = st;
		next_st.sync1 = event_count_input;
		next_st.sync2 = st.sync1;
		next_st.last = st.sync2;
		rise = st.sync2 & ~st.last;
		fall = ~st.sync2 & st.last;
		unique case (edge_sel)
			edge_rising: edge_hit = rise;
			edge_falling: edge_hit = fall;
			edge_both: edge_hit = rise | fall;
			edge_none: edge_hit = 1'b0;
		endcase
		div_hit = (st.div == prescale);
		if (!run || div_hit) begin
			next_st.div = '0;
		end else begin
			next_st.div = st.div + prescale_width'(1);
		end
		tick = run & (use_event ? edge_hit : div_hit);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // count_tick_gen

// File: hw/apb_reg_slave.sv
`timescale 1ns/1ps
// apb slave front end: one-cycle access, decode done by the core
module apb_reg_slave
	import timer_core_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [31:0] rd_value, // value at paddr
	input wire logic addr_ok, // paddr is mapped
	output logic wr_en, // write strobe to core
	output logic [7:0] wr_addr, // write address
	output logic [31:0] wr_data // write data
);
	typedef struct packed {
		logic [31:0] rdata;
	} state_t;

	state_t st, next_st;

	always_comb begin
		next_st = st;
		if (psel && !penable && !pwrite) begin
			next_st.rdata = addr_ok ? rd_value : 32'h0000_0000;
		end
		wr_en = psel & penable & pwrite & addr_ok;
		wr_addr = paddr;
		wr_data = pwdata;
		pready = 1'b1;
		pslverr = psel & penable & ~addr_ok;
		prdata = st.rdata;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // apb_reg_slave

// File: hw/interval_timer_counter_core.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - event count mode: enable rise loads zero, each valid edge adds one
// - other modes start at all ones and roll to zero, one, two
// - match (except in free-run) or capture clears counter; start wrap raises no compare interrupt
// - all-ones wrap is overflow only in free-run and pulse-width modes
// - no overflow at start, on match clear at all ones, or capture clear
// - counter reads live while enabled; reads zero, holds all ones when off
// - three interrupt requests: channel 0, channel 1, overflow
// - both registers writable while running; mode picks anytime or batch, pulse-width mode neither
// - anytime modes copy register writes straight into compare buffers
// - batch modes load both buffers on buffer 0 match once register 1 written
// - mode 000 is interval mode, periodic channel 0 interrupt
// - interval start: all ones to zero, toggle output 0, load buffer 0
// - buffer 0 match clears counter, toggles output 0, raises channel 0
// - buffer 1 still loaded; its match toggles output 1, raises channel 1
// - equal registers give a 50% duty wave on output 1
// - register 0 at zero: counter stays zero, interrupt every count
// - only timer unit 0 drives output 0 pin in interval mode
// - register 0 all ones: match wrap raises channel 0, no overflow
module interval_timer_counter_core
	import timer_core_pkg::*;
#(
	parameter int prescale_width = 16
) (
	input wire logic ref_clk, // system clock, 40 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic event_count_input, // external event / capture pin
	output logic channel0_output, // timer output 0 (unit 0 only)
	output logic channel1_output, // timer output 1
	output logic channel0_irq, // channel 0 request pulse
	output logic channel1_irq, // channel 1 request pulse
	output logic overflow_irq // overflow request pulse
);
	initial begin
		if (prescale_width < 1 || prescale_width > 16) $error("prescale_width out of range");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic count_enable_bit;
		mode_t mode_select_field;
		logic unit0;
		logic event_src;
		edge_sel_t edge_sel;
		logic capture_clear;
		logic [15:0] capture_compare_reg0;
		logic [15:0] capture_compare_reg1;
		logic [15:0] compare_buffer0;
		logic [15:0] compare_buffer1;
		logic [15:0] count;
		logic started;
		logic batch_armed;
		logic overflow_flag;
		logic [prescale_width-1:0] prescale;
		logic cap_s1;
		logic cap_s2;
		logic cap_last;
		logic out0;
		logic out1;
		logic irq0;
		logic irq1;
		logic irq_ov;
	} state_t;

	state_t st, next_st;
	logic tick, wr_en, addr_ok, batch_mode, anytime, at_match0, at_match1;
	logic ovf_mode, cap_edge, do_capture, ovf_event;
	logic [7:0] wr_addr;
	logic [31:0] wr_data, rd_value;

	// ==========================================================
	// count clock
	count_tick_gen #(
		.prescale_width(prescale_width)
	) u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(st.count_enable_bit),
		.use_event(st.event_src || st.mode_select_field == mode_event_count),
		.edge_sel(st.edge_sel),
		.prescale(st.prescale),
		.event_count_input(event_count_input),
		.tick(tick)
	);

	// ==========================================================
	// bus
	apb_reg_slave u_apb (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rd_value(rd_value),
		.addr_ok(addr_ok),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	always_comb begin
		addr_ok = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (paddr)
			ctrl_offset: begin
				rd_value[ctrl_enable_bit] = st.count_enable_bit;
				rd_value[ctrl_mode_lsb +: 3] = st.mode_select_field;
				rd_value[ctrl_unit0_bit] = st.unit0;
				rd_value[ctrl_event_src_bit] = st.event_src;
				rd_value[ctrl_edge_lsb +: 2] = st.edge_sel;
				rd_value[ctrl_capture_clear_bit] = st.capture_clear;
			end
			compare_buffer0_offset: rd_value[15:0] = st.capture_compare_reg0;
			compare_buffer1_offset: rd_value[15:0] = st.capture_compare_reg1;
			count_offset: rd_value[15:0] = st.count_enable_bit ? st.count : count_zero;
			status_offset: begin
				rd_value[status_ovf_bit] = st.overflow_flag;
				rd_value[status_out0_bit] = st.out0;
				rd_value[status_out1_bit] = st.out1;
			end
			prescale_offset: rd_value[prescale_width-1:0] = st.prescale;
			default: addr_ok = 1'b0;
		endcase
	end

	// ==========================================================
	// counter core
	always_comb begin
		next_st = st;
		next_st.irq0 = 1'b0;
		next_st.irq1 = 1'b0;
		next_st.irq_ov = 1'b0;
		next_st.cap_s1 = event_count_input;
		next_st.cap_s2 = st.cap_s1;
		next_st.cap_last = st.cap_s2;
		batch_mode = (st.mode_select_field == mode_ext_trigger) || (st.mode_select_field == mode_pwm);
		anytime = !batch_mode && st.mode_select_field != mode_pulse_width;
		ovf_mode = (st.mode_select_field == mode_free_run) || (st.mode_select_field == mode_pulse_width);
		at_match0 = st.started && st.count == st.compare_buffer0 && st.mode_select_field != mode_pulse_width;
		at_match1 = st.started && st.count == st.compare_buffer1 && st.mode_select_field != mode_pulse_width;
		cap_edge = st.cap_s2 & ~st.cap_last;
		do_capture = st.count_enable_bit && st.started && cap_edge && st.mode_select_field == mode_pulse_width;
		ovf_event = 1'b0;

		// register writes
		if (wr_en) begin
			unique case (wr_addr)
				ctrl_offset: begin
					next_st.count_enable_bit = wr_data[ctrl_enable_bit];
					next_st.mode_select_field = mode_t'(wr_data[ctrl_mode_lsb +: 3]);
					next_st.unit0 = wr_data[ctrl_unit0_bit];
					next_st.event_src = wr_data[ctrl_event_src_bit];
					next_st.edge_sel = edge_sel_t'(wr_data[ctrl_edge_lsb +: 2]);
					next_st.capture_clear = wr_data[ctrl_capture_clear_bit];
				end
				compare_buffer0_offset: begin
					next_st.capture_compare_reg0 = wr_data[15:0];
					if (anytime) next_st.compare_buffer0 = wr_data[15:0];
				end
				compare_buffer1_offset: begin
					next_st.capture_compare_reg1 = wr_data[15:0];
					if (anytime) next_st.compare_buffer1 = wr_data[15:0];
					if (batch_mode) next_st.batch_armed = 1'b1;
				end
				status_offset: if (wr_data[status_ovf_bit]) next_st.overflow_flag = 1'b0;
				prescale_offset: next_st.prescale = wr_data[prescale_width-1:0];
				default: ;
			endcase
		end

		if (!st.count_enable_bit) begin
			next_st.count = count_all_ones;
			next_st.started = 1'b0;
			next_st.batch_armed = 1'b0;
		end else if (!st.started) begin
			if (st.mode_select_field == mode_event_count) begin
				next_st.count = count_zero;
				next_st.started = 1'b1;
				next_st.compare_buffer0 = st.capture_compare_reg0;
				next_st.compare_buffer1 = st.capture_compare_reg1;
			end else if (tick) begin
				next_st.count = count_zero;
				next_st.started = 1'b1;
				next_st.compare_buffer0 = st.capture_compare_reg0;
				next_st.compare_buffer1 = st.capture_compare_reg1;
				if (st.mode_select_field == mode_interval) next_st.out0 = ~st.out0;
			end
		end else if (do_capture) begin
			next_st.capture_compare_reg0 = st.count;
			next_st.irq0 = 1'b1;
			if (st.capture_clear) next_st.count = count_zero;
		end else if (tick) begin
			if (at_match0 && st.mode_select_field != mode_free_run) begin
				next_st.count = count_zero;
				next_st.out0 = ~st.out0;
			end else begin
				next_st.count = st.count + 16'h0001;
				ovf_event = ovf_mode && st.count == count_all_ones;
			end
			if (at_match0) begin
				next_st.irq0 = 1'b1;
				if (batch_mode && st.batch_armed) begin
					next_st.compare_buffer0 = st.capture_compare_reg0;
					next_st.compare_buffer1 = st.capture_compare_reg1;
					next_st.batch_armed = 1'b0;
				end
			end
			if (at_match1) begin
				next_st.irq1 = 1'b1;
				next_st.out1 = ~st.out1;
			end
		end

		if (ovf_event) begin
			next_st.overflow_flag = 1'b1;
			next_st.irq_ov = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.mode_select_field <= mode_interval;
			st.edge_sel <= edge_rising;
			st.capture_compare_reg0 <= ccr_reset;
			st.capture_compare_reg1 <= ccr_reset;
			st.compare_buffer0 <= ccr_reset;
			st.compare_buffer1 <= ccr_reset;
			st.count <= count_all_ones;
			st.prescale <= prescale_width'(prescale_reset);
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		channel0_output = st.unit0 & st.out0;
		channel1_output = st.out1;
		channel0_irq = st.irq0;
		channel1_irq = st.irq1;
		overflow_irq = st.irq_ov;
	end
endmodule // interval_timer_counter_core

// File: verif/interval_timer_counter_core_checker.sv
`timescale 1ns/1ps
module interval_timer_counter_core_checker
	import timer_core_pkg::*;
(
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic event_count_input, // external event pin
	input wire logic channel0_output, // timer output 0
	input wire logic channel1_output, // timer output 1
	input wire logic channel0_irq, // channel 0 request
	input wire logic channel1_irq, // channel 1 request
	input wire logic overflow_irq // overflow request
);
	// ==========================================================
	// shadow of the enable bit and address decode
	logic en_seen;
	logic mapped;
	assign mapped = paddr inside {ctrl_offset, compare_buffer0_offset, compare_buffer1_offset, count_offset, status_offset, prescale_offset};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_seen <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == ctrl_offset) begin
			en_seen <= pwdata[ctrl_enable_bit];
		end
	end

	// ==========================================================
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence access_cyc;
		psel && penable;
	endsequence
	sequence count_read;
		access_cyc ##0 (!pwrite && paddr == count_offset);
	endsequence
	a_ready_always: assert property (pready)
		else $error("pready low");
	a_bad_addr_err: assert property ((access_cyc ##0 !mapped) |-> pslverr)
		else $error("no error on unmapped address");
	a_good_addr_ok: assert property ((access_cyc ##0 mapped) |-> !pslverr)
		else $error("error on mapped address");
	a_bad_read_zero: assert property ((access_cyc ##0 (!pwrite && !mapped)) |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_off_reads_zero: assert property ((count_read ##0 !en_seen) |-> prdata == 32'h0)
		else $error("stopped counter reads nonzero");
	a_quiet_when_off: assert property ((!en_seen && !$past(en_seen)) |-> !(channel0_irq || channel1_irq || overflow_irq))
		else $error("request while stopped");
	a_ovf_single_pulse: assert property (overflow_irq |=> !overflow_irq)
		else $error("overflow request longer than one cycle");
	a_out1_with_irq1: assert property (($changed(channel1_output) && en_seen && $past(en_seen)) |-> (##[0:1] channel1_irq) or $past(channel1_irq))
		else $error("output 1 toggled without channel 1 request");
endmodule // interval_timer_counter_core_checker

bind interval_timer_counter_core interval_timer_counter_core_checker chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .event_count_input, .channel0_output, .channel1_output,
	.channel0_irq, .channel1_irq, .overflow_irq);

// File: verif/interval_timer_counter_core_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("[FAIL] %0t got %h exp %h", $time, g, e); \
	end \
end
module interval_timer_counter_core_bench;
	import timer_core_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic event_count_input = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, channel0_output, channel1_output, channel0_irq, channel1_irq, overflow_irq;
	logic [31:0] q;
	logic err, o0, o1;
	int c;
	int fail_count = 0;
	int tests_run = 0;

	interval_timer_counter_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_count_input(event_count_input), .channel0_output(channel0_output),
		.channel1_output(channel1_output), .channel0_irq(channel0_irq), .channel1_irq(channel1_irq),
		.overflow_irq(overflow_irq));

	always #12.5 ref_clk = ~ref_clk;

	// ==========================================================
	// bus and wait helpers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wait_irq(input int w);
		c = 0;
		while (c < 70000) begin
			@(posedge ref_clk);
			c++;
			if (w == 0 && channel0_irq === 1'b1) break;
			if (w == 2 && overflow_irq === 1'b1) break;
		end
		// a wait that runs out is a mismatch
		if (c == 70000) fail_count++;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset_values();
		apb(0, compare_buffer0_offset, 0);
		`CHK(q, 32'h0000ffff)
		apb(0, count_offset, 0);
		`CHK(q, 32'h0)
		apb(0, 8'h40, 0);
		`CHK({err, q}, {1'b1, 32'h0})
	endtask
	task automatic t_interval();
		apb(1, compare_buffer0_offset, 32'h4);
		apb(1, compare_buffer1_offset, 32'h4);
		apb(1, ctrl_offset, 32'h11);
		wait_irq(0);
		wait_irq(0);
		`CHK(c, 5)
		`CHK(channel1_irq, 1'b1)
		repeat (2) @(posedge ref_clk);
		o0 = channel0_output;
		o1 = channel1_output;
		wait_irq(0);
		repeat (2) @(posedge ref_clk);
		`CHK({channel0_output, channel1_output}, {~o0, ~o1})
		apb(0, count_offset, 0);
		`CHK(q < 32'h5, 1'b1)
		wait_irq(0);
		apb(1, compare_buffer0_offset, 32'h7);
		wait_irq(0);
		wait_irq(0);
		`CHK(c, 8)
		apb(1, ctrl_offset, 32'h0);
		apb(0, count_offset, 0);
		`CHK(q, 32'h0)
	endtask
	task automatic t_zero_interval();
		apb(1, compare_buffer0_offset, 32'h0);
		apb(1, compare_buffer1_offset, 32'hffff);
		apb(1, ctrl_offset, 32'h11);
		wait_irq(0);
		repeat (4) begin
			@(posedge ref_clk);
			`CHK(channel0_irq, 1'b1)
		end
		apb(0, count_offset, 0);
		`CHK(q, 32'h0)
		apb(1, ctrl_offset, 32'h01);
		repeat (2) begin
			@(posedge ref_clk);
			`CHK(channel0_output, 1'b0)
		end
		apb(1, ctrl_offset, 32'h0);
	endtask
	task automatic t_batch();
		apb(1, compare_buffer0_offset, 32'h4);
		apb(1, compare_buffer1_offset, 32'h4);
		apb(1, ctrl_offset, 32'h09);
		wait_irq(0);
		wait_irq(0);
		`CHK(c, 5)
		apb(1, compare_buffer0_offset, 32'h7);
		wait_irq(0);
		wait_irq(0);
		`CHK(c, 5)
		apb(1, compare_buffer1_offset, 32'h4);
		wait_irq(0);
		wait_irq(0);
		`CHK(c, 8)
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK({channel0_irq, channel1_irq, overflow_irq, channel0_output, channel1_output, prdata}, 37'h0)
		rst_n <= 1'b1;
		@(posedge ref_clk);
		apb(0, ctrl_offset, 0);
		`CHK(q, 32'h0)
	endtask
	task automatic t_event_count();
		apb(1, compare_buffer0_offset, 32'hff);
		apb(1, ctrl_offset, 32'h23);
		apb(0, count_offset, 0);
		`CHK(q, 32'h0)
		repeat (3) begin
			event_count_input <= 1'b1;
			repeat (4) @(posedge ref_clk);
			event_count_input <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		apb(0, count_offset, 0);
		`CHK(q, 32'h3)
		apb(1, ctrl_offset, 32'h0);
	endtask
	task automatic t_overflow();
		apb(1, compare_buffer0_offset, 32'hffff);
		apb(1, ctrl_offset, 32'h0b);
		wait_irq(2);
		`CHK(c > 65530 && c < 65545, 1'b1)
		apb(0, status_offset, 0);
		`CHK(q[status_ovf_bit], 1'b1)
		apb(1, status_offset, 32'h1);
		apb(0, status_offset, 0);
		`CHK(q[status_ovf_bit], 1'b0)
		apb(1, ctrl_offset, 32'h0);
	endtask

	// ==========================================================
	// verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset_values();
		t_interval();
		t_zero_interval();
		t_event_count();
		t_overflow();
		t_batch();
		wrap_up();
	end

	initial begin
		#2000000;
		fail_count++;
		wrap_up();
	end
endmodule // interval_timer_counter_core_bench
